// ===== mrs_cfg.svh
// register map, field positions, reset values and timing for the rtu port
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
`define MRS_A_CTRL     8'h00
`define MRS_A_COMMIT   8'h04
`define MRS_A_BAUD     8'h08
`define MRS_A_TMO      8'h0C
`define MRS_A_ADDR     8'h10
`define MRS_A_PRE      8'h14
`define MRS_A_STAT     8'h18
`define MRS_A_MASK     8'h1C
`define MRS_A_TOCNT    8'h20
`define MRS_A_TXD      8'h24
`define MRS_A_GO       8'h28
`define MRS_A_RXD      8'h2C
`define MRS_A_W32      8'h30
`define MRS_A_W32C     8'h34
`define MRS_A_W32O     8'h38
`define MRS_CTRL_W     5
`define MRS_CTRL_RST   5'h01
`define MRS_BAUD_RST   3'h4
`define MRS_TMO_RST    8'h05
`define MRS_ADDR_RST   8'h01
`define MRS_PRE_RST    16'h0032
`define MRS_ST_TXDONE  0
`define MRS_ST_RXBYTE  1
`define MRS_ST_NORESP  2
`define MRS_ST_RESP    3
`define MRS_ST_RXERR   4
`define MRS_ST_W       5
`define MRS_CLK_HZ     200000000
`define MRS_MS_PER_S   1000
`define MRS_TENTH_MS   100
`define MRS_IDLE_BITS  40
`define MRS_DATA_BITS  8
`define MRS_TXBUF_LEN  16
`define MRS_BAUD_0     1200
`define MRS_BAUD_1     2400
`define MRS_BAUD_2     4800
`define MRS_BAUD_3     9600
`define MRS_BAUD_4     19200
`define MRS_BAUD_5     38400
`endif

// ===== mrs_pkg.sv
// types shared by the rtu port modules
`default_nettype none
package mrs_pkg;
   typedef struct packed {
      logic hi_first;
      logic stop2;
      logic par_odd;
      logic par_en;
      logic master;
   } mrs_cfg_t;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PRE  = 5'h02,
      ST_SEND = 5'h04,
      ST_WAIT = 5'h08,
      ST_GAP  = 5'h10
   } mrs_state_t;
endpackage : mrs_pkg
`default_nettype wire

// ===== mrs_char.sv
// character engine: one rtu character out and in, with parity and stops
`timescale 1ns/1ps
`default_nettype none
module mrs_char #(
   parameter int DW = 18
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // format
   input  wire logic [DW-1:0] div,
   input  wire mrs_pkg::mrs_cfg_t cfg,
   // transmit
   input  wire logic          tx_go,
   input  wire logic [7:0]    tx_byte,
   output logic               tx_busy,
   output logic               tx_done,
   output logic               txd,
   // receive
   input  wire logic          rxd,
   output logic               rx_valid,
   output logic [7:0]         rx_byte,
   output logic               rx_err,
   output logic               rx_busy,
   output logic               bit_tick
);
   logic [DW-1:0] tcnt_ff, rcnt_ff, bcnt_ff;
   logic [11:0]   tsh_ff;
   logic [3:0]    tnb_ff, rnb_ff;
   logic [10:0]   rbuf_ff;
   logic          s1_ff, s2_ff;
   logic          par_bit;

   // even parity by default, inverted for odd
   assign par_bit = (^tx_byte) ^ cfg.par_odd;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tsh_ff  <= 12'hFFF;
         tnb_ff  <= 4'h0;
         tcnt_ff <= '0;
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         if (tx_go && !tx_busy) begin
            // always 8 data bits, whatever the format (R3)
            tsh_ff  <= {2'b11, cfg.par_en ? par_bit : 1'b1, tx_byte, 1'b0};
            tnb_ff  <= 4'(10 + 32'(cfg.par_en) + 32'(cfg.stop2)); // R4
            tcnt_ff <= div;
            tx_busy <= 1'b1;
         end else if (tx_busy) begin
            if (tcnt_ff == '0) begin
               tcnt_ff <= div;
               tsh_ff  <= {1'b1, tsh_ff[11:1]};
               tnb_ff  <= tnb_ff - 4'h1;
               if (tnb_ff == 4'h1) begin
                  tx_busy <= 1'b0;
                  tx_done <= 1'b1;
               end
            end else begin
               tcnt_ff <= tcnt_ff - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) txd <= 1'b1;
      else         txd <= tx_busy ? tsh_ff[0] : 1'b1;
   end

   // pin is asynchronous to clk
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
      end else begin
         s1_ff <= rxd;
         s2_ff <= s1_ff;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_busy  <= 1'b0;
         rcnt_ff  <= '0;
         rnb_ff   <= 4'h0;
         rbuf_ff  <= '0;
         rx_valid <= 1'b0;
         rx_byte  <= 8'h00;
         rx_err   <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (!s2_ff) begin
               rx_busy <= 1'b1;
               rcnt_ff <= div >> 1;
               rnb_ff  <= 4'h0;
            end
         end else if (rcnt_ff != '0) begin
            rcnt_ff <= rcnt_ff - 1'b1;
         end else begin
            rcnt_ff           <= div;
            rbuf_ff[rnb_ff]   <= s2_ff;
            rnb_ff            <= rnb_ff + 4'h1;
            // glitch shorter than half a bit is not a start
            if (rnb_ff == 4'h0 && s2_ff) begin
               rx_busy <= 1'b0;
            end else if (rnb_ff == 4'(9 + 32'(cfg.par_en))) begin
               rx_busy  <= 1'b0;
               rx_valid <= 1'b1;
               rx_byte  <= rbuf_ff[8:1]; // R3
               rx_err   <= !s2_ff || (cfg.par_en &&
                  (rbuf_ff[9] != ((^rbuf_ff[8:1]) ^ cfg.par_odd))); // R4
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bcnt_ff  <= '0;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= (bcnt_ff == '0);
         bcnt_ff  <= (bcnt_ff == '0) ? div : bcnt_ff - 1'b1;
      end
   end
endmodule : mrs_char
`default_nettype wire

// ===== mrs_port.sv
// rtu serial port: apb registers, master/slave sequencing, rs485 driver
//
// Contract
// (R1) Master or slave per stored selection; changes apply only on commit.
// (R2) Standard bit rates up to 38400 baud selectable.
// (R3) Every character carries exactly eight data bits.
// (R4) Parity mode and stop bit count are configurable.
// (R5) Master waits up to response time; timer unused in slave mode.
// (R6) Response limit counts in tenths of a second.
// (R7) Expired wait counts a timeout and flags no-response.
// (R8) Zero limit: no wait, every master query ends no-response.
// (R9) Slave answers only its own station number; unused as master.
// (R10) Driver enabled for the turnaround delay before the first character.
// (R11) Turnaround delay also inserted as gap between queries.
// (R12) Fifty milliseconds turnaround is the recommended working value.
// (R13) A 32-bit value spans two consecutive 16-bit registers.
// (R14) Slave uses global word order; master uses per-entry order.
// (R15) High-first puts upper 16 bits in lower-numbered register.
// (R16) Word order affects only 32-bit values, never 16-bit ones.
// (R17) Driver released after final stop bit of last character.
//
// Our own choices: register access over APB and the register addresses.
`include "mrs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mrs_port #(
   parameter int CLK_HZ = `MRS_CLK_HZ,
   parameter int MS_CYC = `MRS_CLK_HZ / `MRS_MS_PER_S,
   parameter int DW     = 18
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt
   output logic             irq,
   // rs485 line
   input  wire logic        rxd,
   output logic             txd,
   output logic             drv_en
);
   if (MS_CYC < 1 || DW < 8 || (CLK_HZ / `MRS_BAUD_0) >= (1 << DW))
   begin : g_bad_param
      $error("mrs_port: parameters out of range");
   end

   mrs_pkg::mrs_cfg_t   pend_ff, act_ff;
   mrs_pkg::mrs_state_t st_ff;
   logic [2:0]  baud_ff;
   logic [7:0]  tmo_ff, addr_ff;
   logic [15:0] pre_ff, tocnt_ff;
   logic [`MRS_ST_W-1:0] stat_ff, mask_ff, ev;
   logic [7:0]  txm [`MRS_TXBUF_LEN];
   logic [4:0]  wptr_ff, rptr_ff, len_ff;
   logic        go_ff, sent_ff;
   logic [31:0] w32_ff, rd_mux;
   logic [1:0]  w32c_ff;
   logic [9:0]  rxd_ff;
   logic [23:0] ms_ff;
   logic [31:0] pcnt_ff;
   logic        ms_tick;
   logic [5:0]  idle_ff;
   logic        first_ff, hit_ff;
   logic        acc, wr, rd_ok;
   logic        tx_go, tx_busy, tx_done, rx_valid, rx_err, rx_busy;
   logic        bit_tick;
   logic [7:0]  rx_byte;
   logic [DW-1:0] div;
   logic        accept, got_resp;

   // tick divisor per rate code (R2)
   function automatic logic [DW-1:0] baud_div(input logic [2:0] c);
      case (c)
         3'h0:    return DW'(CLK_HZ / `MRS_BAUD_0 - 1);
         3'h1:    return DW'(CLK_HZ / `MRS_BAUD_1 - 1);
         3'h2:    return DW'(CLK_HZ / `MRS_BAUD_2 - 1);
         3'h3:    return DW'(CLK_HZ / `MRS_BAUD_3 - 1);
         3'h4:    return DW'(CLK_HZ / `MRS_BAUD_4 - 1);
         default: return DW'(CLK_HZ / `MRS_BAUD_5 - 1);
      endcase
   endfunction : baud_div

   // lower-numbered register in [15:0], next one in [31:16]
   function automatic logic [31:0] word_order(input logic [31:0] v,
                                              input logic is32,
                                              input logic hi);
      return (is32 && hi) ? {v[15:0], v[31:16]} : v; // R15 R16 R13
   endfunction : word_order

   assign div = baud_div(baud_ff);
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite;

   // apb: one wait state, answer registered
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rd_ok;
         if (psel && penable && !pready && !pwrite)
            prdata <= rd_ok ? rd_mux : 32'h0000_0000;
      end
   end

   always_comb begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `MRS_A_CTRL:   rd_mux = 32'(pend_ff);
         `MRS_A_COMMIT: rd_mux = 32'(act_ff);
         `MRS_A_BAUD:   rd_mux = 32'(baud_ff);
         `MRS_A_TMO:    rd_mux = 32'(tmo_ff);
         `MRS_A_ADDR:   rd_mux = 32'(addr_ff);
         `MRS_A_PRE:    rd_mux = 32'(pre_ff);
         `MRS_A_STAT:   rd_mux = 32'(stat_ff);
         `MRS_A_MASK:   rd_mux = 32'(mask_ff);
         `MRS_A_TOCNT:  rd_mux = 32'(tocnt_ff);
         `MRS_A_TXD:    rd_mux = 32'(wptr_ff);
         `MRS_A_GO:     rd_mux = {27'h0, st_ff};
         `MRS_A_RXD:    rd_mux = 32'(rxd_ff);
         `MRS_A_W32:    rd_mux = w32_ff;
         `MRS_A_W32C:   rd_mux = 32'(w32c_ff);
         // slave: global order; master: the entry's own bit (R14)
         `MRS_A_W32O:   rd_mux = word_order(w32_ff, w32c_ff[1],
                           act_ff.master ? w32c_ff[0] : act_ff.hi_first);
         default:       rd_ok  = 1'b0;
      endcase
   end

   // settings; mode, parity and stops only move on commit, the rate applies at once (R1)
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_ff <= `MRS_CTRL_RST;
         act_ff  <= `MRS_CTRL_RST;
         baud_ff <= `MRS_BAUD_RST;
         tmo_ff  <= `MRS_TMO_RST;
         addr_ff <= `MRS_ADDR_RST;
         pre_ff  <= `MRS_PRE_RST;
         mask_ff <= '0;
         w32_ff  <= 32'h0000_0000;
         w32c_ff <= 2'h0;
      end else if (wr) begin
         case (paddr)
            `MRS_A_CTRL:   pend_ff <= pwdata[`MRS_CTRL_W-1:0];
            `MRS_A_COMMIT: act_ff  <= pend_ff; // R1
            `MRS_A_BAUD:   baud_ff <= pwdata[2:0]; // R2
            `MRS_A_TMO:    tmo_ff  <= pwdata[7:0]; // R6
            `MRS_A_ADDR:   addr_ff <= pwdata[7:0];
            `MRS_A_PRE:    pre_ff  <= pwdata[15:0];
            `MRS_A_MASK:   mask_ff <= pwdata[`MRS_ST_W-1:0];
            `MRS_A_W32:    w32_ff  <= pwdata;
            `MRS_A_W32C:   w32c_ff <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // transmit buffer, filled by software between frames
   always_ff @(posedge clk) begin
      if (wr && paddr == `MRS_A_TXD && wptr_ff < 5'(`MRS_TXBUF_LEN))
         txm[wptr_ff[3:0]] <= pwdata[7:0];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wptr_ff <= 5'h00;
         len_ff  <= 5'h00;
         go_ff   <= 1'b0;
      end else begin
         if (wr && paddr == `MRS_A_TXD && wptr_ff < 5'(`MRS_TXBUF_LEN))
            wptr_ff <= wptr_ff + 5'h01;
         // start refused while busy or with nothing queued
         if (wr && paddr == `MRS_A_GO && st_ff == mrs_pkg::ST_IDLE &&
             !go_ff && wptr_ff != 5'h00) begin
            go_ff   <= 1'b1;
            len_ff  <= wptr_ff;
            wptr_ff <= 5'h00;
         end else if (st_ff == mrs_pkg::ST_PRE) begin
            go_ff <= 1'b0;
         end
      end
   end

   // 1 ms base, restarted when a frame starts, when sending ends and when the wait ends
   assign ms_tick = (pcnt_ff == 32'(MS_CYC - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff    <= mrs_pkg::ST_IDLE;
         drv_en   <= 1'b0;
         pcnt_ff  <= 32'h0000_0000;
         ms_ff    <= 24'h00_0000;
         rptr_ff  <= 5'h00;
         sent_ff  <= 1'b0;
         tocnt_ff <= 16'h0000;
      end else begin
         pcnt_ff <= ms_tick ? 32'h0000_0000 : pcnt_ff + 32'h1;
         if (ms_tick) ms_ff <= ms_ff + 24'h1;
         unique case (st_ff)
            mrs_pkg::ST_IDLE: begin
               if (go_ff) begin
                  st_ff   <= mrs_pkg::ST_PRE;
                  drv_en  <= 1'b1; // R10
                  pcnt_ff <= 32'h0000_0000;
                  ms_ff   <= 24'h00_0000;
                  rptr_ff <= 5'h00;
                  sent_ff <= 1'b0;
               end
            end
            mrs_pkg::ST_PRE: begin
               if (ms_ff >= 24'(pre_ff)) st_ff <= mrs_pkg::ST_SEND; // R10
            end
            mrs_pkg::ST_SEND: begin
               if (tx_go) begin
                  rptr_ff <= rptr_ff + 5'h01;
                  sent_ff <= 1'b1;
               end
               if (tx_done && rptr_ff == len_ff) begin
                  drv_en  <= 1'b0; // R17
                  pcnt_ff <= 32'h0000_0000;
                  ms_ff   <= 24'h00_0000;
                  if (!act_ff.master) begin
                     st_ff <= mrs_pkg::ST_IDLE; // R5
                  end else if (tmo_ff == 8'h00) begin
                     st_ff    <= mrs_pkg::ST_GAP; // R8
                     tocnt_ff <= tocnt_ff + 16'h0001;
                  end else begin
                     st_ff <= mrs_pkg::ST_WAIT; // R5
                  end
               end
            end
            mrs_pkg::ST_WAIT: begin
               if (got_resp || ms_ff >= 24'(tmo_ff) * 24'(`MRS_TENTH_MS))
               begin // R6
                  st_ff   <= mrs_pkg::ST_GAP;
                  pcnt_ff <= 32'h0000_0000;
                  ms_ff   <= 24'h00_0000;
                  if (!got_resp) tocnt_ff <= tocnt_ff + 16'h0001; // R7
               end
            end
            mrs_pkg::ST_GAP: begin
               // quiet bus before the next query (R11)
               if (ms_ff >= 24'(pre_ff)) st_ff <= mrs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign tx_go = (st_ff == mrs_pkg::ST_SEND) && !tx_busy && !tx_done &&
                  (rptr_ff != len_ff) && !(sent_ff && rptr_ff == 5'h00);
   // a response during the wait is any first byte heard back
   assign got_resp = (st_ff == mrs_pkg::ST_WAIT) && accept; // R5

   // frame boundary: line silent for about four characters
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_ff  <= 6'h00;
         first_ff <= 1'b1;
         hit_ff   <= 1'b0;
         rxd_ff   <= 10'h000;
      end else begin
         if (rx_busy || rx_valid) idle_ff <= 6'h00;
         else if (bit_tick && idle_ff != 6'(`MRS_IDLE_BITS))
            idle_ff <= idle_ff + 6'h01;
         if (idle_ff == 6'(`MRS_IDLE_BITS)) first_ff <= 1'b1;
         if (rx_valid) begin
            first_ff <= 1'b0;
            // station number only matters in slave mode (R9)
            if (first_ff) hit_ff <= (rx_byte == addr_ff);
         end
         if (accept) rxd_ff <= {first_ff, rx_err, rx_byte};
      end
   end

   assign accept = rx_valid && !drv_en && (act_ff.master ||
                   (first_ff ? (rx_byte == addr_ff) : hit_ff)); // R9

   // sticky status, set wins over a same-cycle clear
   always_comb begin
      ev = '0;
      ev[`MRS_ST_TXDONE] = tx_done && rptr_ff == len_ff &&
                           st_ff == mrs_pkg::ST_SEND;
      ev[`MRS_ST_RXBYTE] = accept;
      ev[`MRS_ST_NORESP] = (st_ff == mrs_pkg::ST_SEND && ev[`MRS_ST_TXDONE]
                           && act_ff.master && tmo_ff == 8'h00) || // R8
                           (st_ff == mrs_pkg::ST_WAIT && !got_resp &&
                           ms_ff >= 24'(tmo_ff) * 24'(`MRS_TENTH_MS)); // R7
      ev[`MRS_ST_RESP]   = got_resp;
      ev[`MRS_ST_RXERR]  = accept && rx_err;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_ff <= '0;
         irq     <= 1'b0;
      end else begin
         stat_ff <= (stat_ff & ~((wr && paddr == `MRS_A_STAT) ?
                    pwdata[`MRS_ST_W-1:0] : '0)) | ev;
         irq     <= |(stat_ff & mask_ff);
      end
   end

   mrs_char #(
      .DW (DW)
   ) u_char (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .div      (div),
      .cfg      (act_ff),
      .tx_go    (tx_go),
      .tx_byte  (txm[rptr_ff[3:0]]),
      .tx_busy  (tx_busy),
      .tx_done  (tx_done),
      .txd      (txd),
      .rxd      (rxd),
      .rx_valid (rx_valid),
      .rx_byte  (rx_byte),
      .rx_err   (rx_err),
      .rx_busy  (rx_busy),
      .bit_tick (bit_tick)
   );
endmodule : mrs_port
`default_nettype wire

// ===== mrs_port_monitor.sv
// assertions on the rtu port pins
`timescale 1ns/1ps
`default_nettype none
module mrs_port_monitor (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // interrupt and line
   input  wire logic        irq,
   input  wire logic        rxd,
   input  wire logic        txd,
   input  wire logic        drv_en
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence access_wait_s;
      psel && penable && !pready;
   endsequence
   sequence turn_on_s;
      $rose(drv_en);
   endsequence
   sequence quiet_line_s;
      txd [*8];
   endsequence

   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("stray pready");
   answer_second_a: assert property (access_wait_s |=> pready)
      else $error("pready late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   slverr_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_err_a: assert property (pready && !pwrite && paddr > 8'h38
      |-> pslverr && prdata == 32'h0)
      else $error("bad unmapped read");
   mapped_ok_a: assert property (pready && paddr <= 8'h38
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   pre_quiet_a: assert property (turn_on_s |-> quiet_line_s)
      else $error("no turnaround");
   start_driven_a: assert property ($fell(txd) |-> drv_en)
      else $error("start bit with driver off");
   release_idle_a: assert property ($fell(drv_en) |-> txd && $past(txd))
      else $error("release mid character");
   off_idle_a: assert property (!drv_en |-> txd)
      else $error("txd low, driver off");
endmodule : mrs_port_monitor
`default_nettype wire

// ===== mrs_rtu_partner.sv
// behavioural rs485 station facing the rtu port
`timescale 1ns/1ps
`default_nettype none
module mrs_rtu_partner #(
   parameter int BC = 16
) (
   // clock
   input  wire logic clk,
   // character format set by the bench
   input  wire logic par_en,
   input  wire logic par_odd,
   input  wire logic stop2,
   // line
   input  wire logic txd,
   input  wire logic drv_en,
   output logic      rxd
);
   logic [7:0] got_q[$];
   logic [7:0] b;
   int         fmt_err;

   // bias holds idle line high
   initial begin
      rxd = 1'b1;
      fmt_err = 0;
   end

   // listen only while the port owns the line
   always begin
      @(negedge txd iff (drv_en === 1'b1));
      repeat (BC / 2) @(posedge clk);
      if (txd !== 1'b0) fmt_err++;
      for (int i = 0; i < 8; i++) begin
         repeat (BC) @(posedge clk);
         b[i] = txd;
      end
      if (par_en) begin
         repeat (BC) @(posedge clk);
         if (txd !== (^b ^ par_odd)) fmt_err++;
      end
      repeat (BC) @(posedge clk);
      if (txd !== 1'b1) fmt_err++;
      if (stop2) begin
         repeat (BC) @(posedge clk);
         if (txd !== 1'b1) fmt_err++;
      end
      got_q.push_back(b);
   end

   task automatic send_byte(input logic [7:0] v);
      rxd <= 1'b0;
      repeat (BC) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd <= v[i];
         repeat (BC) @(posedge clk);
      end
      if (par_en) begin
         rxd <= ^v ^ par_odd;
         repeat (BC) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (stop2 ? 2 * BC : BC) @(posedge clk);
   endtask : send_byte
endmodule : mrs_rtu_partner
`default_nettype wire

// ===== mrs_port_tb_top.sv
// self-checking bench for the rtu serial port
`timescale 1ns/1ps
`default_nettype none
`include "mrs_cfg.svh"
module mrs_port_tb_top;
   // short bit and ms times keep the run small
   localparam int CLK_HZ = 614400;
   localparam int MS_CYC = 20;
   localparam int BC     = CLK_HZ / `MRS_BAUD_5;
   logic        clk, sys_rst, psel, penable, pwrite, rxd, txd, drv_en;
   logic        pready, pslverr, irq, par_en, par_odd, stop2, e;
   logic [7:0]  paddr, rsp;
   logic [31:0] pwdata, prdata, q, v;
   logic [15:0] lfsr;
   logic [7:0]  sent_q[$];
   int          error_cnt, cmp_count, n;
   real         t0;

   mrs_port #(.CLK_HZ(CLK_HZ), .MS_CYC(MS_CYC), .DW(18)) dut (.*);
   mrs_rtu_partner #(.BC(BC)) pm (.*);

   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_step
   function automatic logic [31:0] order32(input logic [31:0] x,
      input logic is32, input logic hi);
      return (is32 && hi) ? {x[15:0], x[31:16]} : x;
   endfunction : order32

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ok(input logic c);
      chk({31'h0, c}, 32'h1);
   endtask : ok
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) error_cnt++;
   endtask : apb
   task automatic wait_drv(input logic lvl);
      n = 0;
      while (drv_en !== lvl && n < 20000) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_drv
   task automatic tx_frame(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         lfsr = lfsr_step(lfsr);
         sent_q.push_back(lfsr[7:0]);
         apb(1'b1, `MRS_A_TXD, {24'h0, lfsr[7:0]});
      end
      apb(1'b1, `MRS_A_GO, 32'h1);
      wait_drv(1'b1);
   endtask : tx_frame
   task automatic w32_sweep(input logic glob, input logic ghi);
      for (int c = 0; c < 4; c++) begin
         lfsr = lfsr_step(lfsr);
         v = {lfsr, lfsr ^ 16'hA5C3};
         apb(1'b1, `MRS_A_W32, v);
         apb(1'b1, `MRS_A_W32C, 32'(c));
         apb(1'b0, `MRS_A_W32O, 32'h0);
         chk(q, order32(v, c[1], glob ? ghi : c[0]));
      end
   endtask : w32_sweep
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // run needs about 9500 cycles
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
      {par_en, par_odd, stop2} = 3'h0;
      lfsr = 16'h0041;
      error_cnt = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, `MRS_A_CTRL, 32'h0);
      chk(q, 32'h1);
      apb(1'b0, `MRS_A_BAUD, 32'h0);
      chk(q, 32'h4);
      apb(1'b0, 8'h3C, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
      // master: odd parity, two stops, fastest rate
      apb(1'b1, `MRS_A_BAUD, 32'h5);
      apb(1'b1, `MRS_A_PRE, 32'h2);
      apb(1'b1, `MRS_A_TMO, 32'h1);
      apb(1'b1, `MRS_A_CTRL, 32'h0F);
      apb(1'b0, `MRS_A_COMMIT, 32'h0);
      chk(q, 32'h1);
      apb(1'b1, `MRS_A_COMMIT, 32'h0);
      apb(1'b0, `MRS_A_COMMIT, 32'h0);
      chk(q, 32'hF);
      {par_en, par_odd, stop2} = 3'h7;
      tx_frame(3);
      n = 0;
      while (txd === 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      ok(n >= 2 * MS_CYC - 1 && n <= 2 * MS_CYC + 3);
      wait_drv(1'b0);
      chk(pm.got_q.size(), sent_q.size());
      while (sent_q.size() > 0) chk(pm.got_q.pop_front(), sent_q.pop_front());
      chk(pm.fmt_err, 0);
      lfsr = lfsr_step(lfsr);
      rsp = lfsr[7:0];
      repeat (45 * BC) @(posedge clk);
      pm.send_byte(rsp);
      repeat (2 * BC) @(posedge clk);
      apb(1'b0, `MRS_A_STAT, 32'h0);
      chk(q, 32'hB);
      apb(1'b0, `MRS_A_RXD, 32'h0);
      chk(q, {22'h0, 2'h2, rsp});
      ok(irq === 1'b0);
      apb(1'b1, `MRS_A_MASK, 32'h8);
      repeat (2) @(posedge clk);
      ok(irq === 1'b1);
      apb(1'b1, `MRS_A_STAT, 32'h1F);
      repeat (2) @(posedge clk);
      ok(irq === 1'b0);
      w32_sweep(1'b0, 1'b0);
      // silent slave: no-response after one tenth
      repeat (6 * MS_CYC) @(posedge clk);
      tx_frame(1);
      wait_drv(1'b0);
      repeat (100 * MS_CYC - 150) @(posedge clk);
      apb(1'b0, `MRS_A_STAT, 32'h0);
      chk(q, 32'h1);
      repeat (300) @(posedge clk);
      apb(1'b0, `MRS_A_STAT, 32'h0);
      chk(q, 32'h5);
      // zero limit: straight to the gap
      apb(1'b1, `MRS_A_TMO, 32'h0);
      apb(1'b1, `MRS_A_STAT, 32'h1F);
      repeat (3 * MS_CYC) @(posedge clk);
      tx_frame(2);
      wait_drv(1'b0);
      t0 = $realtime;
      apb(1'b0, `MRS_A_GO, 32'h0);
      chk(q, 32'h10);
      apb(1'b1, `MRS_A_GO, 32'h1);
      ok(drv_en === 1'b0);
      n = 0;
      while (q !== 32'h1 && n < 40) begin
         apb(1'b0, `MRS_A_GO, 32'h0);
         n++;
      end
      ok(($realtime - t0) >= 2 * MS_CYC * 5.0);
      ok(($realtime - t0) <= (2 * MS_CYC + 12) * 5.0);
      apb(1'b0, `MRS_A_STAT, 32'h0);
      chk(q, 32'h5);
      apb(1'b0, `MRS_A_TOCNT, 32'h0);
      chk(q, 32'h2);
      // slave at station 0x11, upper register first
      apb(1'b1, `MRS_A_ADDR, 32'h11);
      apb(1'b1, `MRS_A_TMO, 32'h1);
      apb(1'b1, `MRS_A_CTRL, 32'h10);
      apb(1'b1, `MRS_A_COMMIT, 32'h0);
      apb(1'b1, `MRS_A_STAT, 32'h1F);
      {par_en, par_odd, stop2} = 3'h0;
      pm.got_q.delete();
      repeat (45 * BC) @(posedge clk);
      pm.send_byte(8'h22);
      pm.send_byte(8'h5A);
      repeat (2 * BC) @(posedge clk);
      apb(1'b0, `MRS_A_STAT, 32'h0);
      chk(q, 32'h0);
      repeat (45 * BC) @(posedge clk);
      pm.send_byte(8'h11);
      pm.send_byte(8'h5A);
      repeat (100 * MS_CYC + 200) @(posedge clk);
      apb(1'b0, `MRS_A_STAT, 32'h0);
      chk(q, 32'h2);
      apb(1'b0, `MRS_A_RXD, 32'h0);
      chk(q, 32'h05A);
      w32_sweep(1'b1, 1'b1);
      report_and_stop();
   end
endmodule : mrs_port_tb_top

bind mrs_port mrs_port_monitor u_mon (.*);
`default_nettype wire
